// [rtl/host_port_pkg.sv]
// shared constants and types for the parallel host port
package host_port_pkg;
    // host interface strap codes, bits {2,1,0}
    localparam logic [2:0] SEL_6800    = 3'h4;  // bit0=0 bit1=0 bit2=1
    localparam logic [2:0] SEL_8080    = 3'h6;  // bit0=0 bit1=1 bit2=1
    localparam logic [2:0] SEL_SPI4    = 3'h0;
    localparam logic [2:0] SEL_SPI3    = 3'h1;  // bit0=1
    localparam logic [2:0] SEL_I2C     = 3'h2;  // bit1=1
    localparam int         DATA_W      = 8;
    localparam int         SYNC_DEPTH  = 3;
    localparam int         STROBE_CYC  = 4;     // sets host strobe width: strobe lasts this plus 5 clocks
    localparam int         FIFO_DEPTH  = 2;
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic [7:0] STATUS_IDLE = 8'h00;

    typedef enum logic [1:0] {
        XFER_RAM_WR,
        XFER_CMD_WR,
        XFER_RAM_RD,
        XFER_STAT_RD
    } xfer_kind_type;

    // decode data_cmd_sel and direction into a transfer kind
    function automatic xfer_kind_type kind_of(input logic dc, input logic rd);
        if (rd) begin
            kind_of = dc ? XFER_RAM_RD : XFER_STAT_RD;
        end else begin
            kind_of = dc ? XFER_RAM_WR : XFER_CMD_WR;
        end
    endfunction
endpackage

// [rtl/host_port_if.sv]
// pin-level carrier between host and display controller
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
    logic       host_sel_bit0;
    logic       host_sel_bit1;
    logic       host_sel_bit2;
    logic       cs_n;
    logic       data_cmd_sel;
    logic       e_rd_n;        // 6800 enable or 8080 read strobe
    logic       rw_wr_n;       // 6800 read/write or 8080 write strobe
    logic       hw_reset_n;
    logic [7:0] host_d_o;
    logic [7:0] host_d_oe;
    logic [7:0] dev_d_o;
    logic [7:0] dev_d_oe;
    logic [7:0] d_bus;
    // resolved pad level, pull low where nobody drives
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            d_bus[i] = dev_d_oe[i] ? dev_d_o[i] : (host_d_oe[i] ? host_d_o[i] : 1'b0);
        end
    end
    modport dev (input host_sel_bit0, host_sel_bit1, host_sel_bit2, cs_n, data_cmd_sel,
                 e_rd_n, rw_wr_n, hw_reset_n, d_bus, output dev_d_o, dev_d_oe);
    modport host (output host_sel_bit0, host_sel_bit1, host_sel_bit2, cs_n, data_cmd_sel,
                  e_rd_n, rw_wr_n, hw_reset_n, host_d_o, host_d_oe, input d_bus);
endinterface
`default_nettype wire

// [rtl/host_port_dev.sv]
// device end: strap decode, parallel strobe decode, byte routing
// What this block does
// - straps select 6800, 8080, SPI or I2C
// - serial modes release data pads 7..2
// - eight-bit pads, driven only on reads
// - 6800 read when read/write line high
// - 6800 write when read/write line low
// - 6800 enable latches while chip select low
// - first display read returns stale pipeline data
// - 8080 read strobe low with chip select
// - 8080 read returns ram or status
// - 8080 write strobe low captures data
// - 8080 write routes to ram or command
// - host dummy-reads before first ram read
// - data_cmd_sel high ram, low status/command
`timescale 1ns/1ps
`default_nettype none
module host_port_dev
    import host_port_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  nrst_i,
    host_port_if.dev                   pins,
    output logic                       wr_valid_o,
    input  wire logic                  wr_ready_i,
    output logic [7:0]                 wr_data_o,
    output logic                       wr_is_ram_o,
    output logic                       rd_ram_req_o,
    input  wire logic [7:0]            ram_rd_data_i,
    input  wire logic [7:0]            status_i,
    output logic [2:0]                 host_sel_o,
    output logic                       serial_mode_o,
    output logic                       serial_clk_o,
    output logic                       serial_data_o,
    output logic                       slave_addr_lsb_o,
    output logic                       overflow_o
);
    import host_port_pkg::*;

    // three-stage synchronisers: cs, dc, e/rd, rw/wr, reset, pads
    localparam int NS = 13;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_reg, s2_reg, s3_reg, st_reg;
    logic [NS-1:0] s1_next, s2_next, s3_next, st_next;
    always_comb begin
        raw     = {pins.d_bus, pins.hw_reset_n, pins.rw_wr_n, pins.e_rd_n,
                   pins.data_cmd_sel, pins.cs_n};
        s1_next = raw;
        s2_next = s1_reg;
        s3_next = s2_reg;
        // a change counts only once stages two and three agree
        st_next = st_reg;
        for (int i = 0; i < NS; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                st_next[i] = s3_reg[i];
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            s1_reg <= 13'h001F;
            s2_reg <= 13'h001F;
            s3_reg <= 13'h001F;
            st_reg <= 13'h001F;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            st_reg <= st_next;
        end
    end

    logic       cs_n, dc, e_rd, rw_wr, hrst_n;
    logic [7:0] din;
    assign cs_n   = st_reg[0];
    assign dc     = st_reg[1];
    assign e_rd   = st_reg[2];
    assign rw_wr  = st_reg[3];
    assign hrst_n = st_reg[4];
    assign din    = st_reg[12:5];

    // straps caught by a clocked process, held in registers
    logic [2:0] sel_reg, sel_next;
    logic       is68, is80, par;
    always_comb begin
        sel_next = {pins.host_sel_bit2, pins.host_sel_bit1, pins.host_sel_bit0};
    end
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sel_reg <= SEL_SPI4;
        end else begin
            sel_reg <= sel_next;
        end
    end
    assign is68 = (sel_reg == SEL_6800);
    assign is80 = (sel_reg == SEL_8080);
    assign par  = is68 | is80;

    // strobe active level per mode, gated by chip select
    logic act, rd_cyc, wr_cyc;
    always_comb begin
        act    = 1'b0;
        rd_cyc = 1'b0;
        wr_cyc = 1'b0;
        if (!cs_n && hrst_n) begin
            if (is68) begin
                act    = e_rd;
                rd_cyc = e_rd & rw_wr;
                wr_cyc = e_rd & ~rw_wr;
            end else if (is80) begin
                rd_cyc = ~e_rd;
                wr_cyc = ~rw_wr & e_rd;
                act    = rd_cyc | wr_cyc;
            end
        end
    end

    // edge tracking and read pipeline
    logic       act_reg, act_next;
    logic [7:0] pipe_reg, pipe_next;     // ram byte fetched by previous read
    logic [7:0] dout_reg, dout_next;
    logic [7:0] oe_reg, oe_next;
    logic       rdreq_reg, rdreq_next;
    logic       push;
    logic       wr_cyc_reg;
    logic       dc_reg;
    xfer_kind_type kind;
    always_comb begin
        act_next   = act;
        pipe_next  = pipe_reg;
        dout_next  = dout_reg;
        rdreq_next = 1'b0;
        push       = 1'b0;
        kind       = kind_of(dc, rd_cyc);
        // drive pads only during a read
        oe_next    = (par && rd_cyc) ? 8'hFF : 8'h00;
        if (act && !act_reg) begin
            if (kind == XFER_STAT_RD) begin
                dout_next = status_i;
            end else if (kind == XFER_RAM_RD) begin
                dout_next  = pipe_reg;
                rdreq_next = 1'b1;
            end
        end
        if (rdreq_reg) begin
            pipe_next = ram_rd_data_i;
        end
        if (!act && act_reg && wr_cyc_reg) begin
            push = 1'b1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || !hrst_n) begin
            act_reg    <= 1'b0;
            pipe_reg   <= BYTE_RESET;
            dout_reg   <= BYTE_RESET;
            oe_reg     <= 8'h00;
            rdreq_reg  <= 1'b0;
            wr_cyc_reg <= 1'b0;
            dc_reg     <= 1'b0;
        end else begin
            act_reg    <= act_next;
            pipe_reg   <= pipe_next;
            dout_reg   <= dout_next;
            oe_reg     <= oe_next;
            rdreq_reg  <= rdreq_next;
            wr_cyc_reg <= act ? wr_cyc : wr_cyc_reg;
            dc_reg     <= act ? dc : dc_reg;
        end
    end
    // pads: data latched while a write cycle is active
    logic [7:0] wbyte_reg;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            wbyte_reg <= BYTE_RESET;
        end else if (wr_cyc) begin
            wbyte_reg <= din;
        end
    end

    // two-entry write buffer, a third write during a consumer stall is dropped and sets overflow
    logic [8:0] buf_mem [FIFO_DEPTH];
    logic       wp_reg, rp_reg, wp_next, rp_next;
    logic [1:0] cnt_reg, cnt_next;
    logic       ovf_reg, ovf_next;
    logic       do_pop, do_push;
    logic [8:0] head;
    always_comb begin
        do_pop   = (cnt_reg != 2'h0) && wr_ready_i;
        do_push  = push && (cnt_reg != 2'h2 || do_pop);
        // forward the entry being written, memory only holds it one edge later
        head     = buf_mem[rp_next];
        if (do_push && (wp_reg == rp_next)) begin
            head = {dc_reg, wbyte_reg};
        end
        wp_next  = do_push ? ~wp_reg : wp_reg;
        rp_next  = do_pop ? ~rp_reg : rp_reg;
        cnt_next = cnt_reg + {1'b0, do_push} - {1'b0, do_pop};
        ovf_next = ovf_reg | (push && !do_push);
    end
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
            ovf_reg <= 1'b0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
            ovf_reg <= ovf_next;
            if (do_push) begin
                buf_mem[wp_reg] <= {dc_reg, wbyte_reg};
            end
        end
    end

    // registered user-side outputs
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            wr_valid_o       <= 1'b0;
            wr_data_o        <= BYTE_RESET;
            wr_is_ram_o      <= 1'b0;
            rd_ram_req_o     <= 1'b0;
            host_sel_o       <= SEL_SPI4;
            serial_mode_o    <= 1'b0;
            serial_clk_o     <= 1'b0;
            serial_data_o    <= 1'b0;
            slave_addr_lsb_o <= 1'b0;
            overflow_o       <= 1'b0;
        end else begin
            wr_valid_o       <= (cnt_next != 2'h0);
            wr_data_o        <= head[7:0];
            wr_is_ram_o      <= head[8];
            rd_ram_req_o     <= rdreq_next;
            host_sel_o       <= sel_reg;
            serial_mode_o    <= !par;
            serial_clk_o     <= din[0];
            serial_data_o    <= din[1];
            slave_addr_lsb_o <= (sel_reg == SEL_I2C) ? dc : 1'b0;
            overflow_o       <= ovf_next;
        end
    end
    assign pins.dev_d_o  = dout_reg;
    assign pins.dev_d_oe = oe_reg;
endmodule
`default_nettype wire

// [rtl/host_port_host.sv]
// host end: drives 6800 or 8080 cycles from a simple request port
`timescale 1ns/1ps
`default_nettype none
module host_port_host
    import host_port_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  nrst_i,
    host_port_if.host                  pins,
    input  wire logic [2:0]            host_sel_i,
    input  wire logic                  req_valid_i,
    output logic                       req_ready_o,
    input  wire logic                  req_read_i,
    input  wire logic                  req_dc_i,
    input  wire logic [7:0]            req_data_i,
    output logic                       rsp_valid_o,
    output logic [7:0]                 rsp_data_o
);
    import host_port_pkg::*;

    typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} state_type;
    state_type  st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       rd_reg, rd_next, dc_reg, dc_next, stb_reg, stb_next;
    logic [7:0] dat_reg, dat_next;
    logic       cs_reg, cs_next, rsp_next;
    logic [7:0] rdat_next;
    logic       is68;
    assign is68 = (host_sel_i == SEL_6800);

    // cycle sequencer: setup, strobe, hold
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        rd_next   = rd_reg;
        dc_next   = dc_reg;
        dat_next  = dat_reg;
        cs_next   = cs_reg;
        stb_next  = 1'b0;
        rsp_next  = 1'b0;
        rdat_next = rsp_data_o;
        case (st_reg)
            IDLE: begin
                if (req_valid_i) begin
                    rd_next  = req_read_i;
                    dc_next  = req_dc_i;
                    dat_next = req_data_i;
                    cs_next  = 1'b0;
                    st_next  = SETUP;
                end
            end
            SETUP: begin
                st_next  = STROBE;
                stb_next = 1'b1;
                cnt_next = 4'(STROBE_CYC + 4);
            end
            STROBE: begin
                stb_next = 1'b1;
                if (cnt_reg == 4'h0) begin
                    stb_next  = 1'b0;
                    rsp_next  = rd_reg;
                    rdat_next = pins.d_bus;
                    cnt_next  = 4'(STROBE_CYC + 4);
                    st_next   = HOLD;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            HOLD: begin
                if (cnt_reg == 4'h0) begin
                    cs_next = 1'b1;
                    st_next = IDLE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: st_next = IDLE;
        endcase
    end
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_reg      <= IDLE;
            cnt_reg     <= 4'h0;
            rd_reg      <= 1'b0;
            dc_reg      <= 1'b0;
            dat_reg     <= BYTE_RESET;
            cs_reg      <= 1'b1;
            stb_reg     <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= BYTE_RESET;
            req_ready_o <= 1'b0;
        end else begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            rd_reg      <= rd_next;
            dc_reg      <= dc_next;
            dat_reg     <= dat_next;
            cs_reg      <= cs_next;
            stb_reg     <= stb_next;
            rsp_valid_o <= rsp_next;
            rsp_data_o  <= rdat_next;
            req_ready_o <= (st_next == IDLE) && !(st_reg == IDLE && req_valid_i);
        end
    end

    // pin mapping: 6800 uses E high and R/W level, 8080 active-low strobes
    assign pins.host_sel_bit0 = host_sel_i[0];
    assign pins.host_sel_bit1 = host_sel_i[1];
    assign pins.host_sel_bit2 = host_sel_i[2];
    assign pins.hw_reset_n    = 1'b1;
    assign pins.cs_n          = cs_reg;
    assign pins.data_cmd_sel  = dc_reg;
    assign pins.e_rd_n        = is68 ? stb_reg : ~(stb_reg & rd_reg);
    assign pins.rw_wr_n       = is68 ? rd_reg : ~(stb_reg & ~rd_reg);
    assign pins.host_d_o      = dat_reg;
    assign pins.host_d_oe     = (!cs_reg && !rd_reg) ? 8'hFF : 8'h00;
endmodule
`default_nettype wire

// [test/host_port_chk.sv]
// wire-level assertions on the host port carrier
`timescale 1ns/1ps
`default_nettype none
module host_port_chk
    import host_port_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic       host_sel_bit0,
    input  wire logic       host_sel_bit1,
    input  wire logic       host_sel_bit2,
    input  wire logic       cs_n,
    input  wire logic       e_rd_n,
    input  wire logic       rw_wr_n,
    input  wire logic [7:0] host_d_oe,
    input  wire logic [7:0] dev_d_oe
);
    logic [2:0] sel;
    logic       m80;
    logic       m68;
    // strap code kept in {bit2,bit1,bit0} order
    assign sel = {host_sel_bit2, host_sel_bit1, host_sel_bit0};
    assign m80 = (sel == SEL_8080);
    assign m68 = (sel == SEL_6800);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    property p_serial_hiz;
        !(m80 || m68) |-> dev_d_oe[7:2] == 6'h00;
    endproperty
    a_serial_hiz: assert property (p_serial_hiz)
        else $error("upper pads driven in serial mode");
    property p_no_fight;
        (dev_d_oe & host_d_oe) == 8'h00;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the data pads");
    property p_wr_host;
        m80 && !cs_n && !rw_wr_n |-> host_d_oe == 8'hFF;
    endproperty
    a_wr_host: assert property (p_wr_host)
        else $error("write strobe without host data");
    // read data must be on the pads well inside the strobe
    property p_rd_8080;
        (m80 && !cs_n && !e_rd_n)[*7] |-> dev_d_oe == 8'hFF;
    endproperty
    a_rd_8080: assert property (p_rd_8080)
        else $error("read strobe not answered on pads");
    property p_rd_6800;
        (m68 && !cs_n && e_rd_n && rw_wr_n)[*7] |-> dev_d_oe == 8'hFF;
    endproperty
    a_rd_6800: assert property (p_rd_6800)
        else $error("enable read not answered on pads");
    property p_wr_6800;
        m68 && !rw_wr_n |-> dev_d_oe == 8'h00;
    endproperty
    a_wr_6800: assert property (p_wr_6800)
        else $error("device drives pads during write");
    property p_cs_idle;
        cs_n[*8] |-> dev_d_oe == 8'h00;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("pads driven while deselected");
    property p_rd_release;
        m80 && $rose(e_rd_n) |-> ##[1:6] dev_d_oe == 8'h00;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("pads held after read strobe");
endmodule
`default_nettype wire

// [test/tb_top.sv]
// bench joining the host end to the device end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import host_port_pkg::*;
    logic       clk_sys_i;
    logic       nrst_i;
    logic       wr_ready_i;
    logic       req_valid_i;
    logic       req_read_i;
    logic       req_dc_i;
    logic       req_ready_o;
    logic       rsp_valid_o;
    logic       wr_valid_o;
    logic       wr_is_ram_o;
    logic       serial_mode_o;
    logic       overflow_o;
    logic [7:0] req_data_i;
    logic [7:0] rsp_data_o;
    logic [7:0] wr_data_o;
    logic [7:0] ram_rd_data_i;
    logic [7:0] status_i;
    logic [2:0] host_sel_i;
    logic [2:0] host_sel_o;
    logic [8:0] wq[$];
    int         failures;
    int         samples_checked;
    host_port_if bus();
    host_port_dev i_host_port_dev (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pins(bus),
        .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_data_o(wr_data_o),
        .wr_is_ram_o(wr_is_ram_o), .rd_ram_req_o(), .ram_rd_data_i(ram_rd_data_i),
        .status_i(status_i), .host_sel_o(host_sel_o), .serial_mode_o(serial_mode_o),
        .serial_clk_o(), .serial_data_o(), .slave_addr_lsb_o(), .overflow_o(overflow_o));
    host_port_host i_host_port_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pins(bus),
        .host_sel_i(host_sel_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_read_i(req_read_i), .req_dc_i(req_dc_i), .req_data_i(req_data_i),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
    host_port_chk i_host_port_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .host_sel_bit0(bus.host_sel_bit0), .host_sel_bit1(bus.host_sel_bit1),
        .host_sel_bit2(bus.host_sel_bit2), .cs_n(bus.cs_n), .e_rd_n(bus.e_rd_n),
        .rw_wr_n(bus.rw_wr_n), .host_d_oe(bus.host_d_oe), .dev_d_oe(bus.dev_d_oe));
    // free-running 200 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // log every byte the consumer takes, kind bit on top
    always @(posedge clk_sys_i) begin
        if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
            wq.push_back({wr_is_ram_o, wr_data_o});
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic hang();
        failures++;
        final_report();
    endtask
    // one edge, keeping any read answer that shows up
    task automatic step(inout logic got, inout logic [7:0] q);
        @(posedge clk_sys_i);
        #1;
        if (rsp_valid_o === 1'b1) begin
            got = 1'b1;
            q = rsp_data_o;
        end
    endtask
    // one host cycle; returns only once chip select is back high
    task automatic xfer(input logic rd, input logic dc, input logic [7:0] d,
                        output logic [7:0] q);
        int   n;
        logic got;
        got = 1'b0;
        q = 8'h00;
        n = 0;
        req_valid_i = 1'b1;
        req_read_i = rd;
        req_dc_i = dc;
        req_data_i = d;
        // ready is registered: its value just after an edge is what the next edge sees
        while (req_ready_o !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        if (n >= 100) hang();
        tick(1);
        req_valid_i = 1'b0;
        while ((bus.cs_n !== 1'b1 || (rd && !got)) && n < 200) begin
            step(got, q);
            n++;
        end
        if (n >= 200) hang();
    endtask
    task automatic set_mode(input logic [2:0] m);
        int n;
        host_sel_i = m;
        n = 0;
        while (host_sel_o !== m && n < 50) begin
            tick(1);
            n++;
        end
        if (n >= 50) hang();
        tick(4);
    endtask
    task automatic t_straps();
        logic [2:0] codes[5];
        logic       ser;
        codes = '{SEL_6800, SEL_8080, SEL_SPI4, SEL_SPI3, SEL_I2C};
        foreach (codes[i]) begin
            set_mode(codes[i]);
            ser = !(codes[i] == SEL_6800 || codes[i] == SEL_8080);
            chk("serial_mode", 9'(serial_mode_o), 9'(ser));
            chk("upper_pads_oe", 9'(bus.dev_d_oe[7:2]), 9'h000);
        end
    endtask
    task automatic t_writes(input logic [2:0] m);
        logic [7:0] q;
        set_mode(m);
        wq.delete();
        xfer(1'b0, 1'b0, 8'hAE, q);
        xfer(1'b0, 1'b1, 8'h7E, q);
        chk("write_count", 9'(wq.size()), 9'h002);
        chk("cmd_write", wq[0], {1'b0, 8'hAE});
        chk("ram_write", wq[1], {1'b1, 8'h7E});
    endtask
    // pipelined ram: each read hands back the previous fetch
    task automatic t_reads(input logic [2:0] m);
        logic [7:0] q;
        set_mode(m);
        xfer(1'b1, 1'b0, 8'h00, q);
        chk("status_read", 9'(q), 9'(status_i));
        ram_rd_data_i = 8'hA5;
        xfer(1'b1, 1'b1, 8'h00, q);
        ram_rd_data_i = 8'h3C;
        xfer(1'b1, 1'b1, 8'h00, q);
        chk("ram_read_1", 9'(q), 9'h0A5);
        ram_rd_data_i = 8'h96;
        xfer(1'b1, 1'b1, 8'h00, q);
        chk("ram_read_2", 9'(q), 9'h03C);
    endtask
    task automatic t_overflow();
        logic [7:0] q;
        set_mode(SEL_8080);
        chk("overflow_clear", 9'(overflow_o), 9'h000);
        wr_ready_i = 1'b0;
        wq.delete();
        xfer(1'b0, 1'b1, 8'h11, q);
        xfer(1'b0, 1'b1, 8'h22, q);
        xfer(1'b0, 1'b0, 8'h33, q);
        chk("stalled_valid", 9'(wr_valid_o), 9'h001);
        chk("overflow_set", 9'(overflow_o), 9'h001);
        wr_ready_i = 1'b1;
        tick(4);
        chk("drain_count", 9'(wq.size()), 9'h002);
        chk("drain_first", wq[0], {1'b1, 8'h11});
        chk("drain_second", wq[1], {1'b1, 8'h22});
        chk("drained_valid", 9'(wr_valid_o), 9'h000);
    endtask
    task automatic do_reset();
        nrst_i = 1'b0;
        tick(3);
        nrst_i = 1'b1;
        tick(4);
    endtask
    // main sequence, ending in a second reset mid-run
    initial begin
        nrst_i = 1'b0;
        wr_ready_i = 1'b1;
        req_valid_i = 1'b0;
        req_read_i = 1'b0;
        req_dc_i = 1'b0;
        req_data_i = 8'h00;
        ram_rd_data_i = 8'h00;
        status_i = 8'h5C;
        host_sel_i = SEL_8080;
        failures = 0;
        samples_checked = 0;
        do_reset();
        t_straps();
        t_writes(SEL_8080);
        t_reads(SEL_8080);
        t_writes(SEL_6800);
        status_i = 8'hC3;
        t_reads(SEL_6800);
        t_overflow();
        do_reset();
        chk("overflow_after_reset", 9'(overflow_o), 9'h000);
        chk("valid_after_reset", 9'(wr_valid_o), 9'h000);
        final_report();
    end
endmodule
`default_nettype wire
